/* src/adc_ctl2_pkg.sv */
// constants and types for the converter control-two block
// assumes one 50 MHz bus clock and a 32-bit classic wishbone register bus
package adc_ctl2_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] ADDR_CTL2  = 8'h00;
  localparam logic [7:0] ADDR_TRIG  = 8'h04;
  localparam logic [7:0] ADDR_EVT   = 8'h08;
  localparam logic [7:0] ADDR_MASK  = 8'h0c;
  localparam logic [7:0] ADDR_STATE = 8'h10;
  // ==========================================================
  // converter_control_two bit positions
  localparam int BIT_POWER_UP   = 7;
  localparam int BIT_FAST_CLEAR = 6;
  localparam int BIT_WAIT_PD    = 5;
  localparam int BIT_LEVEL_SEL  = 4;
  localparam int BIT_POLARITY   = 3;
  localparam int BIT_TRIG_EN    = 2;
  localparam int BIT_IRQ_EN     = 1;
  localparam int BIT_IRQ_FLAG   = 0;
  // trigger select register: channel in [3:0], input select at 4
  localparam int BIT_TRIG_INSEL = 4;
  // event bits of the sticky status and mask registers
  localparam int EV_TRIG   = 0;
  localparam int EV_SEQ    = 1;
  localparam int EV_RESUME = 2;
  localparam int EV_W      = 3;
  // ==========================================================
  // reset values and build options
  localparam logic [7:0]      CTL2_RESET    = 8'h00;
  localparam logic [4:0]      TRIG_RESET    = 5'h00;
  localparam logic [EV_W-1:0] MASK_RESET    = 3'h0;
  localparam logic            HAS_DEDICATED = 1'b1;
  // ==========================================================
  // analog recovery after power-up
  localparam int RECOVERY_NS  = 20000;
  localparam int CLK_NS       = 20;
  localparam int RECOVERY_CYC = (RECOVERY_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOV_W      = 11;

  typedef struct packed {
    logic power_up_bit;
    logic fast_flag_clear;
    logic wait_power_down;
    logic trigger_level_edge_sel;
    logic trigger_polarity;
    logic trigger_enable;
    logic seq_done_irq_enable;
  } ctl_t;

  typedef struct packed {
    logic       trigger_input_select;
    logic [3:0] trigger_channel_field;
  } trig_cfg_t;
endpackage : adc_ctl2_pkg

/* src/adc_power_trigger_irq_control.sv */
// power, wait, trigger and sequence-interrupt control of the converter
// assumes a classic wishbone master, a sequencer that supplies the sequence
// complete flag and result-access strobes on the same clock, asynchronous
// analog-channel digital levels and dedicated trigger pins

module adc_power_trigger_irq_control (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output      logic [31:0] dat_o,
  output      logic        ack_o,
  output      logic        irq_o,
  input  wire logic        seq_complete_i,
  input  wire logic        wait_mode_i,
  input  wire logic        status_two_read_i,
  input  wire logic        result_access_i,
  input  wire logic        result_is_read_i,
  input  wire logic [3:0]  result_index_i,
  input  wire logic [15:0] analog_level_i,
  input  wire logic [3:0]  dedicated_trigger_inputs_i,
  output      logic        abort_o,
  output      logic        analog_on_o,
  output      logic        halted_o,
  output      logic        resume_o,
  output      logic        trig_start_o,
  output      logic [15:0] dib_en_o,
  output      logic [15:0] ccf_clear_o,
  output      logic        seq_irq_req_o
);
  // ==========================================================
  // state
  typedef struct packed {
    adc_ctl2_pkg::ctl_t                     ctl;
    adc_ctl2_pkg::trig_cfg_t                tcfg;
    logic [adc_ctl2_pkg::EV_W-1:0]          evt;
    logic [adc_ctl2_pkg::EV_W-1:0]          mask;
    logic                                   ack;
    logic [31:0]                            dat;
    logic [19:0]                            sync1;
    logic [19:0]                            sync2;
    logic                                   prev_active;
    logic [adc_ctl2_pkg::RECOV_W-1:0]       recov;
    logic                                   armed;
    logic [15:0]                            ccf_clear;
    logic                                   abort;
    logic                                   trig_start;
    logic [15:0]                            dib_en;
    logic                                   analog_on;
    logic                                   halted;
    logic                                   resume;
    logic                                   seq_req;
    logic                                   irq;
    logic                                   scf_prev;
  } state_t;

  state_t s;
  state_t next_s;

  function automatic logic [15:0] onehot16(input logic [3:0] idx);
    onehot16 = 16'h0001 << idx;
  endfunction : onehot16

  // bus qualifiers, one request per ack cycle
  logic bus_wr;
  logic bus_rd;
  logic wr_ctl;
  logic use_dedicated;
  logic reserved_src;
  logic raw_trig;
  logic active_trig;
  logic [adc_ctl2_pkg::EV_W-1:0] ev;
  logic [adc_ctl2_pkg::EV_W-1:0] ev_clr;

  assign bus_wr = cyc_i && stb_i && we_i && !s.ack;
  assign bus_rd = cyc_i && stb_i && !we_i && !s.ack;
  assign wr_ctl = bus_wr && (adr_i == adc_ctl2_pkg::ADDR_CTL2);

  // ==========================================================
  // next state
  always_comb begin
    next_s            = s;
    next_s.ack        = 1'b0;
    next_s.abort      = 1'b0;
    next_s.resume     = 1'b0;
    next_s.ccf_clear  = 16'h0000;
    ev                = '0;
    ev_clr            = '0;

    next_s.sync1 = {dedicated_trigger_inputs_i, analog_level_i};
    next_s.sync2 = s.sync1;

    use_dedicated = adc_ctl2_pkg::HAS_DEDICATED && s.tcfg.trigger_input_select;
    reserved_src  = use_dedicated && (s.tcfg.trigger_channel_field[3:2] != 2'b00);
    raw_trig      = use_dedicated ? s.sync2[16 + s.tcfg.trigger_channel_field[1:0]]
                                  : s.sync2[s.tcfg.trigger_channel_field];

    active_trig        = s.ctl.trigger_polarity ? raw_trig : !raw_trig;
    next_s.prev_active = active_trig;
    next_s.trig_start  = s.ctl.trigger_enable && !reserved_src && !s.halted &&
                         (s.ctl.trigger_level_edge_sel ? active_trig
                                                       : active_trig && !s.prev_active);
    ev[adc_ctl2_pkg::EV_TRIG] = next_s.trig_start && !s.trig_start;

    // digital buffer for analog trigger channel
    next_s.dib_en = (s.ctl.trigger_enable && !use_dedicated)
                    ? onehot16(s.tcfg.trigger_channel_field) : 16'h0000;

    next_s.halted    = wait_mode_i && s.ctl.wait_power_down && s.ctl.power_up_bit;
    // power bit gates the analog section
    next_s.analog_on = s.ctl.power_up_bit && !(wait_mode_i && s.ctl.wait_power_down);
    if (next_s.analog_on && !s.analog_on) begin
      next_s.recov = adc_ctl2_pkg::RECOV_W'(adc_ctl2_pkg::RECOVERY_CYC);
    end else if (!s.analog_on) begin
      next_s.recov = '0;
    end else if (s.recov != '0) begin
      next_s.recov = s.recov - 1'b1;
    end
    if (s.halted && !wait_mode_i) begin
      next_s.resume = 1'b1;
      ev[adc_ctl2_pkg::EV_RESUME] = 1'b1;
    end

    // fast clear on any result access
    if (s.ctl.fast_flag_clear) begin
      next_s.armed = 1'b0;
      if (result_access_i) begin
        next_s.ccf_clear = onehot16(result_index_i);
      end
    end else begin
      // status read arms, result read clears
      if (result_access_i && result_is_read_i && s.armed) begin
        next_s.ccf_clear = onehot16(result_index_i);
        next_s.armed     = 1'b0;
      end
      if (status_two_read_i) begin
        next_s.armed = 1'b1;
      end
    end

    next_s.seq_req  = s.ctl.seq_done_irq_enable && seq_complete_i;
    next_s.scf_prev = seq_complete_i;
    ev[adc_ctl2_pkg::EV_SEQ] = seq_complete_i && !s.scf_prev;

    // ==========================================================
    // register bus
    if (cyc_i && stb_i && !s.ack) begin
      next_s.ack = 1'b1;
    end
    if (bus_wr && sel_i[0]) begin
      case (adr_i)
        adc_ctl2_pkg::ADDR_CTL2: begin
          next_s.ctl = adc_ctl2_pkg::ctl_t'(dat_i[7:1]);
        end
        adc_ctl2_pkg::ADDR_TRIG: begin
          next_s.tcfg = adc_ctl2_pkg::trig_cfg_t'(dat_i[4:0]);
        end
        adc_ctl2_pkg::ADDR_EVT: begin
          ev_clr = dat_i[adc_ctl2_pkg::EV_W-1:0];
        end
        adc_ctl2_pkg::ADDR_MASK: begin
          next_s.mask = dat_i[adc_ctl2_pkg::EV_W-1:0];
        end
        default: begin
        end
      endcase
    end
    if (wr_ctl) begin
      next_s.abort = 1'b1;
    end
    // a new event beats a same-cycle clear
    next_s.evt = (s.evt & ~ev_clr) | ev;
    next_s.irq = |(next_s.evt & next_s.mask);

    if (bus_rd) begin
      case (adr_i)
        adc_ctl2_pkg::ADDR_CTL2: begin
          // flag mirrors complete flag when enabled
          next_s.dat = {24'h000000, s.ctl,
                        s.ctl.seq_done_irq_enable && seq_complete_i};
        end
        adc_ctl2_pkg::ADDR_TRIG: begin
          next_s.dat = {27'h0000000, s.tcfg};
        end
        adc_ctl2_pkg::ADDR_EVT: begin
          next_s.dat = {29'h00000000, s.evt};
        end
        adc_ctl2_pkg::ADDR_MASK: begin
          next_s.dat = {29'h00000000, s.mask};
        end
        adc_ctl2_pkg::ADDR_STATE: begin
          next_s.dat = {27'h0000000, s.armed, s.trig_start, (s.recov != '0),
                        s.halted, s.analog_on};
        end
        default: begin
          next_s.dat = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      next_s_reset();
    end else begin
      s <= next_s;
    end
  end

  // reset values kept in one place; only constants
  task automatic next_s_reset();
    s             <= '0;
    s.ctl         <= adc_ctl2_pkg::ctl_t'(adc_ctl2_pkg::CTL2_RESET[7:1]);
    s.tcfg        <= adc_ctl2_pkg::trig_cfg_t'(adc_ctl2_pkg::TRIG_RESET);
    s.mask        <= adc_ctl2_pkg::MASK_RESET;
  endtask : next_s_reset

  assign dat_o         = s.dat;
  assign ack_o         = s.ack;
  assign irq_o         = s.irq;
  assign abort_o       = s.abort;
  assign analog_on_o   = s.analog_on;
  assign halted_o      = s.halted;
  assign resume_o      = s.resume;
  assign trig_start_o  = s.trig_start;
  assign dib_en_o      = s.dib_en;
  assign ccf_clear_o   = s.ccf_clear;
  assign seq_irq_req_o = s.seq_req;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_write_abort: assert property (wr_ctl |=> abort_o && ack_o)
    else $error("control write did not abort");
  a_abort_cause: assert property (abort_o |-> $past(wr_ctl) && !$past(trig_start_o)
                                   || $past(wr_ctl))
    else $error("abort without control write");
  a_power_off: assert property (!s.ctl.power_up_bit |=> !analog_on_o)
    else $error("analog on while powered down");
  a_recovery: assert property ($rose(analog_on_o) |-> s.recov ==
                               adc_ctl2_pkg::RECOV_W'(adc_ctl2_pkg::RECOVERY_CYC))
    else $error("recovery period not started");
  a_fast_clear: assert property (s.ctl.fast_flag_clear && result_access_i
                                 |=> ccf_clear_o == onehot16($past(result_index_i)))
    else $error("fast clear missed");
  a_normal_clear: assert property (!s.ctl.fast_flag_clear && !s.armed && !status_two_read_i
                                   |=> ccf_clear_o == 16'h0000)
    else $error("flag cleared without status read");
  a_wait_halt: assert property (wait_mode_i && s.ctl.wait_power_down && s.ctl.power_up_bit
                                |=> halted_o && !analog_on_o)
    else $error("converter not halted in wait");
  a_wait_resume: assert property (halted_o && !wait_mode_i |=> resume_o ##1 !resume_o)
    else $error("no single resume pulse");
  a_edge_once: assert property (!s.ctl.trigger_level_edge_sel && trig_start_o
                                && $stable(s.ctl) |=> !trig_start_o)
    else $error("edge trigger longer than a pulse");
  a_trig_off: assert property (!s.ctl.trigger_enable |=> !trig_start_o)
    else $error("trigger while disabled");
  a_dib_enable: assert property (s.ctl.trigger_enable && !s.tcfg.trigger_input_select
                                 |=> dib_en_o == onehot16($past(s.tcfg.trigger_channel_field)))
    else $error("trigger channel buffer not enabled");
  a_seq_request: assert property (s.ctl.seq_done_irq_enable && seq_complete_i
                                  |=> seq_irq_req_o)
    else $error("sequence request missing");
  a_flag_read: assert property (bus_rd && adr_i == adc_ctl2_pkg::ADDR_CTL2
                                |=> dat_o[0] == ($past(s.ctl.seq_done_irq_enable)
                                                 && $past(seq_complete_i)))
    else $error("interrupt flag read wrong");

  c_abort:  cover property (wr_ctl ##1 abort_o);
  c_fast:   cover property (s.ctl.fast_flag_clear && result_access_i ##1 |ccf_clear_o);
  c_trig:   cover property (s.ctl.trigger_enable ##[1:20] trig_start_o);
  c_resume: cover property (halted_o ##[1:20] resume_o);
endmodule : adc_power_trigger_irq_control

/* verif/tb_top.sv */
// self-checking bench for the converter power, trigger and interrupt control
// assumes the design package and module from src/, one 50 MHz clock
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, seq = 1'b0, wmode = 1'b0;
  logic        racc = 1'b0, rrd = 1'b0, st2 = 1'b0, aborted;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hf, ridx = 4'h0, dtrig = 4'h0;
  logic [31:0] wdat = 32'h0, dat_o, q;
  logic [15:0] alev = 16'h0, dib_en_o, ccf_clear_o, clr;
  logic        ack_o, irq_o, abort_o, analog_on_o, halted_o, resume_o, trig_start_o;
  logic        seq_irq_req_o;
  int          fails = 0, check_count = 0, cycles = 0, n;
  logic [7:0]  row_adr [0:4] = '{8'h00, 8'h04, 8'h0c, 8'h14, 8'h00};
  logic [7:0]  row_wr  [0:4] = '{8'hff, 8'h1f, 8'h02, 8'haa, 8'h00};
  logic [7:0]  row_exp [0:4] = '{8'hfe, 8'h1f, 8'h02, 8'h00, 8'h00};

  adc_power_trigger_irq_control u_adc_power_trigger_irq_control (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
    .seq_complete_i(seq), .wait_mode_i(wmode), .status_two_read_i(st2),
    .result_access_i(racc), .result_is_read_i(rrd), .result_index_i(ridx),
    .analog_level_i(alev), .dedicated_trigger_inputs_i(dtrig), .abort_o(abort_o),
    .analog_on_o(analog_on_o), .halted_o(halted_o), .resume_o(resume_o),
    .trig_start_o(trig_start_o), .dib_en_o(dib_en_o), .ccf_clear_o(ccf_clear_o),
    .seq_irq_req_o(seq_irq_req_o));

  always #10 clk_i = ~clk_i;

  // ==========================================================
  // shared tasks
  task automatic give_verdict;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      $display("wrong value t=%0t %s got %h exp %h", $time, msg, got, exp);
      fails++;
    end
  endtask : chk

  // classic cycle: hold until ack is sampled at a rising edge, release there
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    q = dat_o;
    aborted = abort_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(q, exp, "register read");
  endtask : rd

  // one-cycle sequencer strobes, clear pulse sampled the cycle after
  task automatic pulse(input logic acc, input logic r, input logic s, input logic [3:0] i);
    @(posedge clk_i);
    racc <= acc;
    rrd  <= r;
    st2  <= s;
    ridx <= i;
    @(posedge clk_i);
    racc <= 1'b0;
    st2  <= 1'b0;
    @(negedge clk_i);
    clr = ccf_clear_o;
  endtask : pulse

  task automatic settle(input int k);
    repeat (k) @(posedge clk_i);
    @(negedge clk_i);
  endtask : settle

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      give_verdict();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk({irq_o, analog_on_o, halted_o, trig_start_o}, 0, "reset outputs");
    for (int i = 0; i < 4; i++) rd(8'(i * 4), 0);
    // table of register writes and readbacks
    for (int i = 0; i < 5; i++) begin
      wb(1'b1, row_adr[i], {24'h0, row_wr[i]});
      if (row_adr[i] == 8'h00) chk(aborted, 1, "abort on write");
      rd(row_adr[i], {24'h0, row_exp[i]});
    end
    // all four sensitivities on analog channel 0
    wb(1'b1, 8'h04, 32'h0);
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_i);
      alev[0] <= ~m[0];
      wb(1'b1, 8'h00, 32'h04 | (m[1] << 4) | (m[0] << 3));
      settle(4);
      chk(trig_start_o, 0, "idle trigger");
      alev[0] <= m[0];
      settle(2);
      chk(trig_start_o, 0, "sync delay");
      settle(1);
      chk(trig_start_o, 1, "trigger start");
      settle(1);
      chk(trig_start_o, m[1], "edge pulse or level");
    end
    wb(1'b1, 8'h00, 32'h08);
    alev[0] <= 1'b0;
    settle(3);
    n = 0;
    alev[0] <= 1'b1;
    repeat (6) begin
      settle(1);
      if (trig_start_o !== 1'b0) n++;
    end
    chk(n, 0, "disabled trigger");
    rd(8'h08, 32'h01);
    chk(irq_o, 0, "masked event");
    wb(1'b1, 8'h04, 32'h05);
    wb(1'b1, 8'h00, 32'h04);
    settle(2);
    chk(dib_en_o, 16'h0020, "buffer enable");
    // sequence complete interrupt, mask and clear
    wb(1'b1, 8'h08, 32'h07);
    wb(1'b1, 8'h0c, 32'h02);
    wb(1'b1, 8'h00, 32'h02);
    seq <= 1'b1;
    settle(3);
    chk({seq_irq_req_o, irq_o}, 2'b11, "irq request");
    rd(8'h00, 32'h03);
    rd(8'h08, 32'h02);
    wb(1'b1, 8'h08, 32'h02);
    rd(8'h08, 32'h00);
    settle(1);
    chk(irq_o, 0, "event cleared");
    wb(1'b1, 8'h00, 32'h00);
    settle(2);
    chk(seq_irq_req_o, 0, "irq disabled");
    rd(8'h00, 32'h00);
    seq <= 1'b0;
    wb(1'b1, 8'h00, 32'h80);
    settle(2);
    chk(analog_on_o, 1, "powered");
    rd(8'h10, 32'h05);
    chk(q[2], 1, "recovering");
    wmode <= 1'b1;
    settle(3);
    chk({analog_on_o, halted_o}, 2'b10, "runs in wait");
    wmode <= 1'b0;
    wb(1'b1, 8'h00, 32'ha0);
    wmode <= 1'b1;
    settle(3);
    chk({analog_on_o, halted_o}, 2'b01, "halted in wait");
    wmode <= 1'b0;
    n = 0;
    repeat (4) begin
      settle(1);
      if (resume_o === 1'b1) n++;
    end
    chk(n, 1, "one resume pulse");
    chk({analog_on_o, halted_o}, 2'b10, "running again");
    rd(8'h08, 32'h04);
    chk(q[2], 1, "resume event");
    // narrow write still aborts, stores nothing
    sel <= 4'h0;
    wb(1'b1, 8'h00, 32'hff);
    sel <= 4'hf;
    chk(aborted, 1, "abort without store");
    rd(8'h00, 32'ha0);
    wb(1'b1, 8'h00, 32'hc0);
    pulse(1'b1, 1'b0, 1'b0, 4'h3);
    chk(clr, 16'h0008, "fast clear");
    wb(1'b1, 8'h00, 32'h80);
    pulse(1'b1, 1'b1, 1'b0, 4'h2);
    chk(clr, 16'h0000, "unarmed read");
    pulse(1'b0, 1'b0, 1'b1, 4'h0);
    pulse(1'b1, 1'b1, 1'b0, 4'h2);
    chk(clr, 16'h0004, "armed read");
    give_verdict();
  end
endmodule : tb_top
